// ===== inc/psb_pkg.sv
package psb_pkg;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int unsigned CLK_HZ          = 100_000_000;
    localparam int unsigned SWITCH_HZ       = 100_000;
    // Counts in one switching period at the core clock rate.
    localparam int unsigned PERIOD_CYCLES   = CLK_HZ / SWITCH_HZ;
    // Nominal time-base resolution of one period.
    localparam int unsigned PERIOD_COUNTS   = 600;
    localparam int unsigned CNT_W           = 11;
    localparam int unsigned DB_W            = 8;

    // ************************************************************
    // Register map (APB byte addresses)
    // ************************************************************
    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_PHASE  = 8'h04;
    localparam logic [7:0] OFF_DEAD   = 8'h08;
    localparam logic [7:0] OFF_STATUS = 8'h0C;

    // Control register fields.
    localparam int unsigned CTRL_EN_BIT    = 0;
    localparam int unsigned CTRL_LOOP_BIT  = 1;
    localparam int unsigned CTRL_MODE_LSB  = 4;
    // Dead-time register fields.
    localparam int unsigned DEAD_END_LSB   = 0;
    localparam int unsigned DEAD_START_LSB = 16;

    // Reset values.
    localparam logic [CNT_W-1:0] PHASE_RST    = 11'h000;
    localparam logic [DB_W-1:0]  DEAD_END_RST = 8'h10;
    localparam logic [DB_W-1:0]  DEAD_STA_RST = 8'h10;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [1:0] {
        RECT_DIODE = 2'h0,
        RECT_IDEAL = 2'h1,
        RECT_FULL  = 2'h2
    } rect_mode_t;

    typedef struct packed {
        logic [CNT_W-1:0] phase;
        logic [DB_W-1:0]  end_dead;
        logic [DB_W-1:0]  start_dead;
        rect_mode_t       rect_mode;
    } pwm_cfg_t;

    typedef struct packed {
        logic starting_leg_upper_switch;
        logic starting_leg_lower_switch;
        logic ending_leg_upper_switch;
        logic ending_leg_lower_switch;
        logic rectifier_switch_a;
        logic rectifier_switch_b;
    } gate_t;

endpackage : psb_pkg

// ===== hw/dead_band_leg.sv
`timescale 1ns/1ps
// Turns a raw 50% leg phase into two complementary gates with dead time.
module dead_band_leg #(
    parameter int unsigned DW = 8
) (
    // Clock and reset.
    input  wire logic          core_clk,
    input  wire logic          rst_n,
    // Leg command.
    input  wire logic          run,
    input  wire logic          raw_high,
    input  wire logic [DW-1:0] dead,
    // Gates.
    output logic               upper_on,
    output logic               lower_on
);

    // ************************************************************
    // Edge delay
    // ************************************************************
    logic          prev_r;
    logic [DW-1:0] wait_r;

    // A fresh edge of the raw leg restarts the dead time; both gates stay
    // off until it expires, so the two switches never conduct together.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_r   <= 1'b0;
            wait_r   <= '0;
            upper_on <= 1'b0;
            lower_on <= 1'b0;
        end else if (!run) begin
            prev_r   <= raw_high;
            wait_r   <= dead;
            upper_on <= 1'b0;
            lower_on <= 1'b0;
        end else begin
            prev_r <= raw_high;
            if (raw_high != prev_r) begin
                wait_r   <= dead;
                upper_on <= 1'b0;
                lower_on <= 1'b0;
            end else if (wait_r != '0) begin
                wait_r <= wait_r - 1'b1;
            end else begin
                upper_on <= raw_high;
                lower_on <= ~raw_high;
            end
        end
    end

endmodule : dead_band_leg

// ===== hw/phase_shift_bridge_pwm.sv
`timescale 1ns/1ps
module phase_shift_bridge_pwm
    import psb_pkg::*;
#(
    parameter int unsigned PERIOD = PERIOD_CYCLES
) (
    // Clock and reset.
    input  wire logic                  core_clk,
    input  wire logic                  rst_n,
    // APB slave.
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [7:0]            paddr,
    input  wire logic [31:0]           pwdata,
    output logic [31:0]                prdata,
    output logic                       pready,
    output logic                       pslverr,
    // Protection.
    input  wire logic                  overcurrent_trip,
    // Gate drives.
    output psb_pkg::gate_t             gate,
    output logic                       period_start
);
    import psb_pkg::*;

    // ************************************************************
    // Software-visible settings
    // ************************************************************
    // Each setting is one aligned 32-bit word. The regulator writes the
    // shadow copy at any time and the generator picks it up at the next
    // wrap, or on the next clock while disabled. Reads return the copy in force, so software can tell whether a
    // new command has been taken yet. A phase above half a period is
    // clamped, and an undefined rectifier code is stored as diode mode.
    localparam logic [CNT_W-1:0] HALF = CNT_W'(PERIOD / 2);
    localparam logic [CNT_W-1:0] LAST = CNT_W'(PERIOD - 1);

    logic             enable_r;
    logic             loop_sel_r;
    pwm_cfg_t         shadow_r;
    pwm_cfg_t         active_r;
    logic             tripped_r;
    logic [CNT_W-1:0] cnt_r;
    logic             boundary;
    logic             apb_wr;
    logic             apb_rd;
    logic [CNT_W-1:0] phase_clamped;
    logic [1:0]       mode_wr;

    assign apb_wr = psel && penable && pwrite;
    assign apb_rd = psel && penable && !pwrite;

    // Oversized commands clamp to half a period, where overlap peaks.
    assign phase_clamped = (pwdata[CNT_W-1:0] > HALF) ? HALF : pwdata[CNT_W-1:0];
    // Unknown mode codes fall back to diode mode, the safe choice.
    assign mode_wr = (pwdata[CTRL_MODE_LSB +: 2] > 2'h2) ? 2'h0
                                                         : pwdata[CTRL_MODE_LSB +: 2];

    // Shadow settings written by the regulator; the loop-select bit only
    // labels the command source, it does not touch waveform generation.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            enable_r            <= 1'b0;
            loop_sel_r          <= 1'b0;
            shadow_r.phase      <= PHASE_RST;
            shadow_r.end_dead   <= DEAD_END_RST;
            shadow_r.start_dead <= DEAD_STA_RST;
            shadow_r.rect_mode  <= RECT_DIODE;
        end else if (apb_wr) begin
            case (paddr)
                OFF_CTRL: begin
                    enable_r           <= pwdata[CTRL_EN_BIT];
                    loop_sel_r         <= pwdata[CTRL_LOOP_BIT];
                    shadow_r.rect_mode <= rect_mode_t'(mode_wr);
                end
                OFF_PHASE: begin
                    shadow_r.phase <= phase_clamped;
                end
                OFF_DEAD: begin
                    shadow_r.end_dead   <= pwdata[DEAD_END_LSB +: DB_W];
                    shadow_r.start_dead <= pwdata[DEAD_START_LSB +: DB_W];
                end
                default: begin
                end
            endcase
        end
    end

    // APB answers in the access cycle; unmapped addresses raise pslverr.
    // The answer is prepared at the setup edge, so pready, prdata and
    // pslverr all come straight from flip-flops with no wait state.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
            if (psel && !penable) begin
                case (paddr)
                    OFF_CTRL: prdata <= {26'h0, active_r.rect_mode, 2'h0,
                                         loop_sel_r, enable_r};
                    OFF_PHASE: prdata <= {21'h0, active_r.phase};
                    OFF_DEAD: prdata <= {8'h00, active_r.start_dead,
                                         8'h00, active_r.end_dead};
                    OFF_STATUS: prdata <= {20'h0, cnt_r, tripped_r};
                    default: pslverr <= 1'b1;
                endcase
            end
        end
    end

    // ************************************************************
    // Time base
    // ************************************************************
    assign boundary = (cnt_r == LAST);

    // One period of PERIOD clock cycles, 10 us at 100 MHz.
    // While disabled the count rests at zero, so enabling always starts a
    // clean period with the ending leg high.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= '0;
        end else if (boundary || !enable_r) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    // Settings move into the generator only at the wrap, so a period never
    // mixes old and new values, but a mode change cuts short a full-mode rectifier B pulse that spans the wrap.
    // While disabled the generator follows the shadow every cycle, so the
    // first enabled period runs with settings written before the enabling write; a mode set in that same write waits for the first wrap.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            active_r.phase      <= PHASE_RST;
            active_r.end_dead   <= DEAD_END_RST;
            active_r.start_dead <= DEAD_STA_RST;
            active_r.rect_mode  <= RECT_DIODE;
            period_start        <= 1'b0;
        end else begin
            period_start <= boundary;
            if (boundary || !enable_r) begin
                active_r <= shadow_r;
            end
        end
    end

    // Trip latches and holds until reset; nothing in software clears it.
    // A bridge that tripped once is not trusted again without a full
    // restart, so there is deliberately no clear bit.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tripped_r <= 1'b0;
        end else if (overcurrent_trip) begin
            tripped_r <= 1'b1;
        end
    end

    // ************************************************************
    // Raw leg phases
    // ************************************************************
    logic             end_raw;
    logic             start_raw;
    logic [CNT_W:0]   shifted;
    logic [CNT_W-1:0] start_pos;
    logic             run;

    // Ending leg is the reference: high for the first half period.
    assign end_raw = (cnt_r < HALF);
    // Starting leg is the same square wave advanced by the phase count, so
    // the ending leg lags it by the phase. Each overlap then opens on a
    // starting-leg edge and closes on an ending-leg edge, and lasts as long
    // as the phase count. The phase is clamped to half a period, so the sum
    // stays below two periods and one conditional subtraction wraps it.
    assign shifted   = {1'b0, cnt_r} + {1'b0, active_r.phase};
    assign start_pos = (shifted >= {1'b0, CNT_W'(PERIOD)})
                       ? CNT_W'(shifted - {1'b0, CNT_W'(PERIOD)})
                       : shifted[CNT_W-1:0];
    assign start_raw = (start_pos < HALF);
    assign run       = enable_r && !tripped_r && !overcurrent_trip;

    logic end_up;
    logic end_lo;
    logic sta_up;
    logic sta_lo;

    // One dead-band stage per leg, each with its own dead time: the ending
    // leg switches at high winding current and the starting leg near zero
    // current, so the two need different settings as the load changes.
    dead_band_leg #(.DW(DB_W)) u_end_leg (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .run      (run),
        .raw_high (end_raw),
        .dead     (active_r.end_dead),
        .upper_on (end_up),
        .lower_on (end_lo)
    );

    dead_band_leg #(.DW(DB_W)) u_start_leg (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .run      (run),
        .raw_high (start_raw),
        .dead     (active_r.start_dead),
        .upper_on (sta_up),
        .lower_on (sta_lo)
    );

    // ************************************************************
    // Rectifier and output stage
    // ************************************************************
    // Diagonal pairs: ending-upper with starting-lower, ending-lower with
    // starting-upper. Each raw overlap is as long as the phase count and
    // occurs once per period: pair A at the end of the first half, pair B
    // at the end of the second half, closing on the wrap.
    logic  diag_a;
    logic  diag_b;
    logic  rect_a;
    logic  rect_b;
    gate_t gate_nxt;

    assign diag_a = end_raw && !start_raw;
    assign diag_b = !end_raw && start_raw;

    // Rectifier gates come from the raw overlaps under the active period's
    // mode. The mode only changes at the wrap, where overlap B closes; in full
    // mode rectifier B stays on across the wrap below a half-period phase, so a change into or out of full mode cuts that pulse short.
    // Mode 0 gives up the conduction gain to save switching loss at light
    // load; the rectifiers carry no dead time of their own.
    always_comb begin
        case (active_r.rect_mode)
            RECT_DIODE: begin
                rect_a = 1'b0;
                rect_b = 1'b0;
            end
            RECT_IDEAL: begin
                rect_a = diag_a;
                rect_b = diag_b;
            end
            RECT_FULL: begin
                rect_a = !diag_b;
                rect_b = !diag_a;
            end
            default: begin
                rect_a = 1'b0;
                rect_b = 1'b0;
            end
        endcase
    end

    // Next gate word. The raw trip input is part of run, so the very cycle
    // in which a trip shows up already builds an all-off word.
    always_comb begin
        gate_nxt = '0;
        if (run) begin
            gate_nxt.ending_leg_upper_switch   = end_up;
            gate_nxt.ending_leg_lower_switch   = end_lo;
            gate_nxt.starting_leg_upper_switch = sta_up;
            gate_nxt.starting_leg_lower_switch = sta_lo;
            gate_nxt.rectifier_switch_a        = rect_a;
            gate_nxt.rectifier_switch_b        = rect_b;
        end
    end

    // Registered outputs, so the gate drivers never see a combinational
    // hazard; a trip input forces all six low on the next edge.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            gate <= '0;
        end else begin
            gate <= gate_nxt;
        end
    end

endmodule : phase_shift_bridge_pwm

// ===== dv/gate_drv_model.sv
`timescale 1ns/1ps
// Gate-driver stand-in: tallies each switch's on-time over one period.
module gate_drv_model
    import psb_pkg::*;
(
    // Clock and reset.
    input  wire logic           core_clk,
    input  wire logic           rst_n,
    // Gate drives.
    input  wire psb_pkg::gate_t gate,
    input  wire logic           period_start,
    // Observations.
    output logic [5:0][7:0]     on_cnt,
    output logic [7:0]          a_rises,
    output logic                shoot
);
    logic [5:0][7:0] acc_r;
    logic [7:0]      rise_r;
    logic            a_prev_r;

    // Windows open at each period pulse so every tally spans one full period.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_r <= '0;
            on_cnt <= '0;
            rise_r <= '0;
            a_rises <= '0;
            a_prev_r <= 1'b0;
            shoot <= 1'b0;
        end else begin
            a_prev_r <= gate.rectifier_switch_a;
            // A real bridge leg would short the bus here, so it is sticky.
            if ((gate[5] && gate[4]) || (gate[3] && gate[2])) begin
                shoot <= 1'b1;
            end
            if (period_start) begin
                on_cnt <= acc_r;
                a_rises <= rise_r;
                rise_r <= '0;
                for (int i = 0; i < 6; i++) acc_r[i] <= {7'h00, gate[i]};
            end else begin
                for (int i = 0; i < 6; i++) acc_r[i] <= acc_r[i] + {7'h00, gate[i]};
                rise_r <= rise_r + {7'h00, gate.rectifier_switch_a && !a_prev_r};
            end
        end
    end
endmodule : gate_drv_model

// ===== dv/phase_shift_bridge_pwm_assertions.sv
`timescale 1ns/1ps
// Port-level checks of the bridge gate generator.
module psb_checker
    import psb_pkg::*;
#(
    parameter int unsigned PERIOD = PERIOD_CYCLES
) (
    input wire logic           core_clk,
    input wire logic           rst_n,
    input wire logic           psel,
    input wire logic           penable,
    input wire logic           pwrite,
    input wire logic [7:0]     paddr,
    input wire logic [31:0]    pwdata,
    input wire logic [31:0]    prdata,
    input wire logic           pready,
    input wire logic           pslverr,
    input wire logic           overcurrent_trip,
    input wire psb_pkg::gate_t gate,
    input wire logic           period_start
);
    logic [15:0] gap_r;
    logic        seen_r;
    logic        tripped_r;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    // Distance between period pulses; the first pulse only arms the count.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            gap_r <= '0;
            seen_r <= 1'b0;
            tripped_r <= 1'b0;
        end else begin
            gap_r <= period_start ? 16'h0000 : gap_r + 16'h0001;
            seen_r <= seen_r | period_start;
            tripped_r <= tripped_r | overcurrent_trip;
        end
    end

    start_comp_a:
        assert property (!(gate.starting_leg_upper_switch && gate.starting_leg_lower_switch))
        else $error("starting leg both on");
    end_comp_a:
        assert property (!(gate.ending_leg_upper_switch && gate.ending_leg_lower_switch))
        else $error("ending leg both on");
    start_dead_a:
        assert property ($rose(gate.starting_leg_upper_switch)
            |-> $past(gate.starting_leg_lower_switch) == 1'b0) else $error("no start dead time");
    end_dead_a:
        assert property ($rose(gate.ending_leg_lower_switch)
            |-> $past(gate.ending_leg_upper_switch) == 1'b0) else $error("no end dead time");
    trip_off_a:
        assert property (overcurrent_trip |=> (gate == '0) [*4]) else $error("trip not obeyed");
    trip_hold_a:
        assert property (tripped_r |-> gate == '0) else $error("gates back after trip");
    period_len_a:
        assert property (period_start && seen_r |-> gap_r == 16'(PERIOD - 1))
        else $error("period length wrong");
    apb_answer_a:
        assert property (psel && !penable |=> pready) else $error("apb answer late");
    err_ready_a:
        assert property (pslverr |-> pready) else $error("error without ready");

    first_open_a:
        assert property ($rose(gate.ending_leg_upper_switch && gate.starting_leg_lower_switch)
            |-> $rose(gate.starting_leg_lower_switch))
        else $error("overlap A not opened by starting leg");
    second_open_a:
        assert property ($rose(gate.ending_leg_lower_switch && gate.starting_leg_upper_switch)
            |-> $rose(gate.starting_leg_upper_switch))
        else $error("overlap B not opened by starting leg");
    first_close_a:
        assert property ($fell(gate.ending_leg_upper_switch && gate.starting_leg_lower_switch)
            |-> $fell(gate.ending_leg_upper_switch))
        else $error("overlap A not closed by ending leg");
    second_close_a:
        assert property ($fell(gate.ending_leg_lower_switch && gate.starting_leg_upper_switch)
            |-> $fell(gate.ending_leg_lower_switch))
        else $error("overlap B not closed by ending leg");

    cover property (overcurrent_trip);
    cover property (period_start && seen_r);
    cover property (pslverr);
endmodule : psb_checker

bind phase_shift_bridge_pwm psb_checker #(.PERIOD(PERIOD)) psb_checker_inst (
    .core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .overcurrent_trip(overcurrent_trip), .gate(gate), .period_start(period_start));

// ===== dv/tb_phase_shift_bridge_pwm.sv
`timescale 1ns/1ps
// Register-level bench for the bridge gate generator.
module tb_phase_shift_bridge_pwm;
    import psb_pkg::*;
    localparam int unsigned P  = 40;
    localparam int unsigned DE = 2;
    localparam int unsigned DS = 3;
    logic            core_clk = 1'b0;
    logic            rst_n = 1'b0;
    logic            psel = 1'b0;
    logic            penable = 1'b0;
    logic            pwrite = 1'b0;
    logic [7:0]      paddr = 8'h00;
    logic [31:0]     pwdata = 32'h0000_0000;
    logic            overcurrent_trip = 1'b0;
    logic [31:0]     prdata;
    logic            pready;
    logic            pslverr;
    gate_t           gate;
    logic            period_start;
    logic [5:0][7:0] on_cnt;
    logic [7:0]      a_rises;
    logic            shoot;
    int              fail_count = 0;
    int              total_checks = 0;
    int unsigned     ph;
    logic [31:0]     q;
    logic            e;

    // Free-running core clock.
    always #5 core_clk = ~core_clk;

    phase_shift_bridge_pwm #(.PERIOD(P)) phase_shift_bridge_pwm_inst (
        .core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .overcurrent_trip(overcurrent_trip), .gate(gate), .period_start(period_start));
    gate_drv_model gate_drv_model_inst (
        .core_clk(core_clk), .rst_n(rst_n), .gate(gate), .period_start(period_start),
        .on_cnt(on_cnt), .a_rises(a_rises), .shoot(shoot));

    task automatic finish_test();
        if (fail_count == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // One APB transfer; the request holds until pready is sampled high.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            chk("pready", 32'h1, 32'h0);
            finish_test();
        end
    endtask : apb

    task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m,
                      input logic err);
        apb(1'b0, a, 32'h0000_0000);
        chk("prdata", x, q & m);
        chk("pslverr", {31'h0, err}, {31'h0, e});
    endtask : rd

    // Bounded wait for k period pulses.
    task automatic wait_ps(input int k);
        int n;
        repeat (k) begin
            n = 0;
            do begin
                @(posedge core_clk);
                n++;
            end while (period_start !== 1'b1 && n < 200);
            if (period_start !== 1'b1) begin
                chk("period_start", 32'h1, 32'h0);
                finish_test();
            end
        end
    endtask : wait_ps

    // Full-period on-times: each leg gate loses dead+1 cycles of its half period.
    task automatic meas(input int unsigned m);
        logic [7:0] r;
        wait_ps(3);
        #1;
        r = (m == 1) ? 8'(ph) : (m == 2) ? 8'(P - ph) : 8'h00;
        chk("start upper", 32'(P / 2 - DS - 1), {24'h0, on_cnt[5]});
        chk("start lower", 32'(P / 2 - DS - 1), {24'h0, on_cnt[4]});
        chk("end upper", 32'(P / 2 - DE - 1), {24'h0, on_cnt[3]});
        chk("end lower", 32'(P / 2 - DE - 1), {24'h0, on_cnt[2]});
        chk("rect a", {24'h0, r}, {24'h0, on_cnt[1]});
        chk("rect b", {24'h0, r}, {24'h0, on_cnt[0]});
        if (m == 1) chk("rect a pulses", 32'h1, {24'h0, a_rises});
    endtask : meas

    initial begin
        repeat (20) @(posedge core_clk);
        rst_n <= 1'b1;
        rd(OFF_CTRL, 32'h0, 32'hFFFF_FFFF, 1'b0);
        rd(OFF_DEAD, {8'h00, DEAD_STA_RST, 8'h00, DEAD_END_RST}, 32'hFFFF_FFFF, 1'b0);
        rd(8'h10, 32'h0, 32'hFFFF_FFFF, 1'b1);
        apb(1'b1, OFF_DEAD, 32'((DS << 16) | DE));
        apb(1'b1, OFF_PHASE, 32'h0000_001E);
        rd(OFF_PHASE, 32'(P / 2), 32'hFFFF_FFFF, 1'b0);
        // Both loop selections and every rectifier mode, each at two phases.
        for (int l = 0; l < 2; l++) begin
            for (int m = 0; m < 3; m++) begin
                apb(1'b1, OFF_CTRL, 32'(1 | (l << 1) | (m << 4)));
                for (int k = 0; k < 2; k++) begin
                    ph = (k == 1) ? P / 2 : 8;
                    apb(1'b1, OFF_PHASE, 32'(ph));
                    meas(m);
                end
            end
        end
        wait_ps(1);
        apb(1'b1, OFF_PHASE, 32'h0000_0008);
        rd(OFF_PHASE, 32'(P / 2), 32'hFFFF_FFFF, 1'b0);
        wait_ps(1);
        rd(OFF_PHASE, 32'h0000_0008, 32'hFFFF_FFFF, 1'b0);
        // An undefined rectifier code must come back as diode mode.
        apb(1'b1, OFF_CTRL, 32'h0000_0031);
        wait_ps(1);
        rd(OFF_CTRL, 32'h0000_0001, 32'hFFFF_FFFF, 1'b0);
        overcurrent_trip <= 1'b1;
        @(posedge core_clk);
        overcurrent_trip <= 1'b0;
        repeat (2) @(posedge core_clk);
        repeat (P) begin
            @(posedge core_clk);
            chk("gate", 32'h0, {26'h0, gate});
        end
        rd(OFF_STATUS, 32'h1, 32'h1, 1'b0);
        chk("shoot", 32'h0, {31'h0, shoot});
        finish_test();
    end
endmodule : tb_phase_shift_bridge_pwm
